// ==== cxs_can_node.sv ====
/*
  Other CAN nodes, reduced to the controller flags they cause.
  Assumes the testbench calls its tasks from one process.
*/
`timescale 1ns/100ps
module cxs_can_node (
  // Clock
  input wire pclk,
  // Controller flags
  output logic act,
  output logic tick,
  output logic fv
);
  initial begin
    act = 1'b0;
    tick = 1'b0;
    fv = 1'b0;
  end
  // Recessive bit times only, so the bus looks idle
  task ticks(input int n);
    repeat (n) begin
      @(posedge pclk) tick <= 1'b1;
      @(posedge pclk) tick <= 1'b0;
    end
  endtask
  task sof();
    @(posedge pclk) act <= 1'b1;
    @(posedge pclk) act <= 1'b0;
  endtask
  // A node resends a frame that went unacknowledged, so losing one is harmless
  // A frame that fails its checks ends without the valid flag
  task frame(input logic ok);
    sof();
    repeat (3) @(posedge pclk);
    fv <= ok;
    @(posedge pclk) fv <= 1'b0;
  endtask
endmodule // cxs_can_node

// ==== cxs_chk.sv ====
/*
  Checker for the sleep and wake controller, bound to its ports.
  Assumes the short simulation counts of the testbench.
*/
`timescale 1ns/100ps
module cxs_chk #(
  parameter NGPIO = 8
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Watched ports
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire [31:0] prdata,
  input wire can_activity,
  input wire can_rx_ack_en,
  input wire can_listen_only,
  input wire [NGPIO-1:0] gpio_out,
  input wire [NGPIO-1:0] gpio_oe,
  input wire adc_run,
  input wire auto_conv_run,
  input wire auto_msg_run,
  input wire pwm_run,
  input wire clkout_run,
  input wire core_hold,
  input wire asleep
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_sleep_halts_runs: assert property (asleep |->
    !(adc_run | auto_conv_run | auto_msg_run | pwm_run | clkout_run)) else $error("peripheral runs while asleep");
  a_pins_hold: assert property (asleep && $past(asleep) |-> $stable(gpio_out) && $stable(gpio_oe))
    else $error("pin drive moved in sleep");
  a_can_wakes: assert property (asleep && can_activity |-> ##[1:2] !asleep)
    else $error("no wake on bus activity");
  a_wake_holds: assert property ($fell(asleep) |-> ##[0:1] core_hold)
    else $error("no start-up hold on wake");
  a_wake_no_ack: assert property (asleep && can_activity |=> !can_rx_ack_en [*3])
    else $error("wake frame acknowledged");
  a_activity_restart: assert property (can_activity && !asleep |=> !asleep)
    else $error("sleep right after activity");
  a_hold_quiet: assert property (core_hold |-> !auto_msg_run && !pwm_run)
    else $error("outputs run during hold");
  a_hold_listen: assert property (core_hold || asleep |-> can_listen_only)
    else $error("normal mode before start-up ends");
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no apb answer");
  a_apb_err_read: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("refused read not zero");
endmodule // cxs_chk

bind cxs_sleep_ctrl cxs_chk #(.NGPIO(NGPIO)) i_chk (.pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr,
  .prdata, .can_activity, .can_rx_ack_en, .can_listen_only, .gpio_out, .gpio_oe, .adc_run, .auto_conv_run,
  .auto_msg_run, .pwm_run, .clkout_run, .core_hold, .asleep);

// ==== cxs_map.vh ====
/*
  Register offsets, field positions, reset values and timing counts for the
  CAN expander sleep and wake controller.
  Assumes an APB slave with 32-bit data, one aligned word per register.
*/
// Summary of operation
// R1: Sleep after 1408 idle bit times, normal mode
// R2: Power-up sleep in listen-only when bus quiet
// R3: After power-up wake, listen-only until valid message
// R4: Pins hold their drive state while asleep
// R5: Sleep halts ADC, auto modes, PWM, clock out
// R6: Wake on reset pin, GPIO edge, bus activity
// R7: GPIO wake needs that pin's enable bit
// R8: GPIO wake ignores global interrupt enable
// R9: Wake frame is neither received nor acknowledged
// R10: Hold 512 oscillator periods after wake or reset
// R11: Wake keeps registers; reset pin clears them
// R12: Idle counter clears on activity or disable
`ifndef CXS_MAP_VH
`define CXS_MAP_VH

`define CXS_OFF_OPTION 12'h000
`define CXS_OFF_TXC_EN 12'h004
`define CXS_OFF_GPIO_OUT 12'h008
`define CXS_OFF_GPIO_OE 12'h00C
`define CXS_OFF_STATUS 12'h010

`define CXS_OPT_SLEEP_EN 0
`define CXS_OPT_POWERUP_SLEEP_ENABLE_EN 1
`define CXS_OPT_GIE 2

`define CXS_ST_ASLEEP 0
`define CXS_ST_LISTEN 1
`define CXS_ST_RUN 2
`define CXS_ST_WAKE_SRC_LO 3

`define CXS_OPTION_RST 8'h00
`define CXS_IDLE_BITS 1408
`define CXS_OST_PERIODS 512

`endif

// ==== cxs_sleep_ctrl.v ====
/*
  Sleep and wake controller: idle detection, power-up sleep, peripheral
  halts, pin hold, wake sources and oscillator start-up hold.
  Assumes a CAN controller that flags bus activity, bit ticks and valid
  frames on the pclk domain, and an APB master for configuration.
*/
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/100ps
`include "cxs_map.vh"
module cxs_sleep_ctrl #(
  parameter NGPIO = 8,
  parameter IDLE_BITS = `CXS_IDLE_BITS,
  parameter OST_PERIODS = `CXS_OST_PERIODS
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // External reset pin and GPIO pins, asynchronous
  input wire ext_rst_n,
  input wire [NGPIO-1:0] gpio_in,
  // CAN controller, same clock
  input wire can_activity,
  input wire can_bit_tick,
  input wire can_frame_valid,
  output reg can_rx_ack_en,
  output reg can_listen_only,
  // GPIO pin drive
  output reg [NGPIO-1:0] gpio_out,
  output reg [NGPIO-1:0] gpio_oe,
  // Peripheral run enables, start-up hold and sleep flag
  output reg adc_run,
  output reg auto_conv_run,
  output reg auto_msg_run,
  output reg pwm_run,
  output reg clkout_run,
  output reg core_hold,
  output reg asleep
);
  localparam ST_OST = 5'b00001;
  localparam ST_PUCHK = 5'b00010;
  localparam ST_RUN = 5'b00100;
  localparam ST_SLEEP = 5'b01000;
  localparam ST_LISTEN = 5'b10000;

  reg [4:0] state_ff, nxt_state;
  reg [10:0] idle_cnt_ff;
  reg [9:0] ost_cnt_ff;
  reg pu_sleep_ff, nxt_pu_sleep;
  reg drop_frame_ff, nxt_drop_frame;
  reg [1:0] wake_src_ff, nxt_wake_src;
  reg [7:0] option_ff;
  reg [NGPIO-1:0] txc_en_ff;
  reg [NGPIO-1:0] gpio_out_reg_ff;
  reg [NGPIO-1:0] gpio_oe_reg_ff;
  reg [NGPIO-1:0] gpio_prev_ff;
  reg rst_prev_ff;
  wire [NGPIO-1:0] gpio_s;
  wire rst_s;
  wire sleep_en = option_ff[`CXS_OPT_SLEEP_EN];
  wire powerup_sleep_enable_en = option_ff[`CXS_OPT_POWERUP_SLEEP_ENABLE_EN];
  wire [NGPIO-1:0] gpio_edge = gpio_s ^ gpio_prev_ff;
  // Enable per pin only; the global enable bit plays no part
  wire gpio_wake = |(gpio_edge & txc_en_ff); // R7 R8
  wire rst_fall = rst_prev_ff & ~rst_s;
  wire apb_wr = psel & penable & pwrite;
  localparam [31:0] IDLE_LAST = IDLE_BITS - 1;
  localparam [31:0] OST_LAST = OST_PERIODS - 1;
  wire [10:0] idle_last = IDLE_LAST[10:0];
  wire [9:0] ost_last = OST_LAST[9:0];

  function addr_ok;
    input [11:0] a;
    begin
      addr_ok = (a == `CXS_OFF_OPTION) || (a == `CXS_OFF_TXC_EN) || (a == `CXS_OFF_GPIO_OUT) ||
        (a == `CXS_OFF_GPIO_OE) || (a == `CXS_OFF_STATUS);
    end
  endfunction

  cxs_sync3 #(.W(NGPIO + 1)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({ext_rst_n, gpio_in}),
    .dout({rst_s, gpio_s})
  );

  // Reset pin handled as a clocked register reset, so wake by pin clears state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_prev_ff <= 1'b0;
      gpio_prev_ff <= {NGPIO{1'b0}};
    end else begin
      rst_prev_ff <= rst_s;
      gpio_prev_ff <= gpio_s;
    end
  end

  // Registers survive wake; only the pin or power-on reset clears them
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      option_ff <= `CXS_OPTION_RST;
      txc_en_ff <= {NGPIO{1'b0}};
      gpio_out_reg_ff <= {NGPIO{1'b0}};
      gpio_oe_reg_ff <= {NGPIO{1'b0}};
    end else if (rst_fall) begin // R11
      option_ff <= `CXS_OPTION_RST;
      txc_en_ff <= {NGPIO{1'b0}};
      gpio_out_reg_ff <= {NGPIO{1'b0}};
      gpio_oe_reg_ff <= {NGPIO{1'b0}};
    end else if (apb_wr) begin
      case (paddr)
        `CXS_OFF_OPTION: option_ff <= pwdata[7:0];
        `CXS_OFF_TXC_EN: txc_en_ff <= pwdata[NGPIO-1:0];
        `CXS_OFF_GPIO_OUT: gpio_out_reg_ff <= pwdata[NGPIO-1:0];
        `CXS_OFF_GPIO_OE: gpio_oe_reg_ff <= pwdata[NGPIO-1:0];
        default: option_ff <= option_ff;
      endcase
    end
  end

  // APB answers in the access cycle; read data registered at setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok(paddr);
      prdata <= 32'h00000000;
      if (psel & ~penable & ~pwrite) begin
        case (paddr)
          `CXS_OFF_OPTION: prdata <= {24'h000000, option_ff};
          `CXS_OFF_TXC_EN: prdata[NGPIO-1:0] <= txc_en_ff;
          `CXS_OFF_GPIO_OUT: prdata[NGPIO-1:0] <= gpio_out_reg_ff;
          `CXS_OFF_GPIO_OE: prdata[NGPIO-1:0] <= gpio_oe_reg_ff;
          `CXS_OFF_STATUS: prdata[4:0] <= {wake_src_ff, (state_ff == ST_RUN), can_listen_only, asleep};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  always @* begin
    nxt_state = state_ff;
    nxt_pu_sleep = pu_sleep_ff;
    nxt_drop_frame = drop_frame_ff;
    nxt_wake_src = wake_src_ff;
    case (state_ff)
      ST_OST: begin
        if (ost_cnt_ff == ost_last) begin // R10
          // A bus wake must lose its frame, so any bus wake waits in listen-only
          if (pu_sleep_ff || drop_frame_ff) begin
            nxt_state = ST_LISTEN; // R3 R9
          end else if (wake_src_ff == 2'd0 && powerup_sleep_enable_en) begin
            nxt_state = ST_PUCHK;
          end else begin
            nxt_state = ST_RUN;
          end
        end
      end
      ST_PUCHK: begin
        // Listen-only after power-up; quiet bus sends the device to sleep
        if (can_activity) begin
          nxt_state = ST_LISTEN;
        end else begin
          nxt_state = ST_SLEEP; // R2
          nxt_pu_sleep = 1'b1;
        end
      end
      ST_LISTEN: begin
        // Wake frame is dropped; the next valid frame releases normal mode
        if (can_frame_valid) begin
          if (drop_frame_ff) begin
            nxt_drop_frame = 1'b0; // R9
          end else begin
            nxt_state = ST_RUN; // R3
            nxt_pu_sleep = 1'b0;
          end
        end
      end
      ST_RUN: begin
        if (sleep_en && idle_cnt_ff == idle_last && can_bit_tick && !can_activity) begin
          nxt_state = ST_SLEEP; // R1
        end
      end
      ST_SLEEP: begin
        if (can_activity) begin // R6
          nxt_state = ST_OST;
          nxt_drop_frame = 1'b1; // R9
          nxt_wake_src = 2'd3;
        end else if (gpio_wake) begin // R6
          nxt_state = ST_OST;
          nxt_wake_src = 2'd2;
        end
      end
      default: nxt_state = ST_OST;
    endcase
    if (rst_fall) begin // R6 R11
      nxt_state = ST_OST;
      nxt_pu_sleep = 1'b0;
      nxt_drop_frame = 1'b0;
      nxt_wake_src = 2'd1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_OST;
      pu_sleep_ff <= 1'b0;
      drop_frame_ff <= 1'b0;
      wake_src_ff <= 2'd0;
      ost_cnt_ff <= 10'd0;
      idle_cnt_ff <= 11'd0;
    end else begin
      state_ff <= nxt_state;
      pu_sleep_ff <= nxt_pu_sleep;
      drop_frame_ff <= nxt_drop_frame;
      wake_src_ff <= nxt_wake_src;
      if (state_ff != ST_OST || nxt_state != ST_OST || rst_fall) begin
        ost_cnt_ff <= 10'd0;
      end else begin
        ost_cnt_ff <= ost_cnt_ff + 10'd1; // R10
      end
      if (!sleep_en || can_activity || state_ff != ST_RUN) begin
        idle_cnt_ff <= 11'd0; // R12
      end else if (can_bit_tick && idle_cnt_ff != idle_last) begin
        idle_cnt_ff <= idle_cnt_ff + 11'd1; // R1
      end
    end
  end

  // Outputs follow the next state so they change with it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpio_out <= {NGPIO{1'b0}};
      gpio_oe <= {NGPIO{1'b0}};
      adc_run <= 1'b0;
      auto_conv_run <= 1'b0;
      auto_msg_run <= 1'b0;
      pwm_run <= 1'b0;
      clkout_run <= 1'b0;
      core_hold <= 1'b1;
      asleep <= 1'b0;
      can_listen_only <= 1'b1;
      can_rx_ack_en <= 1'b0;
    end else begin
      if (nxt_state != ST_SLEEP) begin
        gpio_out <= gpio_out_reg_ff;
        gpio_oe <= gpio_oe_reg_ff; // R4
      end
      adc_run <= (nxt_state == ST_RUN) || (nxt_state == ST_LISTEN); // R5
      auto_conv_run <= nxt_state == ST_RUN; // R5
      auto_msg_run <= nxt_state == ST_RUN; // R5
      pwm_run <= (nxt_state == ST_RUN) || (nxt_state == ST_LISTEN); // R5
      clkout_run <= (nxt_state != ST_SLEEP) && (nxt_state != ST_OST); // R5
      core_hold <= nxt_state == ST_OST; // R10
      asleep <= nxt_state == ST_SLEEP;
      can_listen_only <= nxt_state != ST_RUN; // R3
      can_rx_ack_en <= (nxt_state == ST_RUN) || (nxt_state == ST_LISTEN && !nxt_drop_frame); // R9
    end
  end
endmodule // cxs_sleep_ctrl

// ==== cxs_sync3.v ====
/*
  Three-stage input synchroniser with agreement filter.
  Assumes asynchronous pin inputs and a single clock domain.
*/
`timescale 1ns/100ps
module cxs_sync3 #(
  parameter W = 1
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Data
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);
  reg [W-1:0] s1_ff;
  reg [W-1:0] s2_ff;
  reg [W-1:0] s3_ff;
  integer i;
  // Stage one feeds only stage two; output moves when stages two and three agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= {W{1'b0}};
      s2_ff <= {W{1'b0}};
      s3_ff <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      for (i = 0; i < W; i = i + 1) begin
        if (s2_ff[i] == s3_ff[i]) begin
          dout[i] <= s3_ff[i];
        end
      end
    end
  end
endmodule // cxs_sync3

// ==== testbench.sv ====
/*
  Self-checking bench for the sleep and wake controller.
  Assumes short idle and hold counts (8 bit times, 4 cycles).
*/
`timescale 1ns/100ps
`include "cxs_map.vh"
module testbench;
  logic pclk, presetn, psel, penable, pwrite, ext_rst_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, err, act, tick, fv, ack_en, listen, hold, asleep;
  logic adc, aconv, amsg, pwm, clko;
  logic [7:0] gpio_in, gpio_out, gpio_oe;
  int n_fail = 0;
  int samples_checked = 0;
  cxs_sleep_ctrl #(.NGPIO(8), .IDLE_BITS(8), .OST_PERIODS(4)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_rst_n(ext_rst_n), .gpio_in(gpio_in), .can_activity(act),
    .can_bit_tick(tick), .can_frame_valid(fv), .can_rx_ack_en(ack_en), .can_listen_only(listen),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .adc_run(adc), .auto_conv_run(aconv), .auto_msg_run(amsg),
    .pwm_run(pwm), .clkout_run(clko), .core_hold(hold), .asleep(asleep));
  cxs_can_node i_node (.pclk(pclk), .act(act), .tick(tick), .fv(fv));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task pins(input logic r, input logic [7:0] g);
    ext_rst_n <= r;
    gpio_in <= g;
  endtask
  task hold_end();
    for (int i = 0; i < 40 && hold !== 1'b0; i++) @(posedge pclk);
    chk(hold, 1'b0);
  endtask
  task go_sleep();
    i_node.sof();
    i_node.ticks(8);
    repeat (3) @(posedge pclk);
    chk(asleep, 1'b1);
  endtask
  task t_regs();
    apb(1'b0, `CXS_OFF_OPTION, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `CXS_OFF_STATUS, 32'h0);
    chk(rd, 32'h4);
    apb(1'b0, 12'h020, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
  endtask
  task t_idle();
    apb(1'b1, `CXS_OFF_OPTION, 32'h1);
    apb(1'b1, `CXS_OFF_GPIO_OUT, 32'hA5);
    apb(1'b1, `CXS_OFF_GPIO_OE, 32'h0F);
    i_node.sof();
    i_node.ticks(7);
    i_node.sof();
    i_node.ticks(7);
    repeat (3) @(posedge pclk);
    chk(asleep, 1'b0);
    i_node.ticks(1);
    repeat (3) @(posedge pclk);
    chk(asleep, 1'b1);
    chk({adc, aconv, amsg, pwm, clko}, 5'h00);
    apb(1'b1, `CXS_OFF_GPIO_OUT, 32'hFF);
    chk({gpio_out, gpio_oe}, 16'hA50F);
  endtask
  task t_can_wake();
    i_node.sof();
    repeat (2) @(posedge pclk);
    chk({asleep, hold}, 2'b01);
    hold_end();
    chk({listen, ack_en}, 2'b10);
    chk(gpio_out, 8'hFF);
    i_node.frame(1'b1);
    repeat (2) @(posedge pclk);
    chk(listen, 1'b1);
    i_node.frame(1'b1);
    repeat (2) @(posedge pclk);
    chk(listen, 1'b0);
  endtask
  task t_gpio_wake();
    apb(1'b1, `CXS_OFF_TXC_EN, 32'h01);
    go_sleep();
    pins(1'b1, 8'h02);
    repeat (8) @(posedge pclk);
    chk(asleep, 1'b1);
    pins(1'b1, 8'h03);
    repeat (8) @(posedge pclk);
    chk(asleep, 1'b0);
    hold_end();
    apb(1'b0, `CXS_OFF_STATUS, 32'h0);
    chk(rd[4:3], 2'd2);
  endtask
  task t_pin_reset();
    go_sleep();
    pins(1'b0, 8'h03);
    repeat (8) @(posedge pclk);
    pins(1'b1, 8'h03);
    repeat (8) @(posedge pclk);
    hold_end();
    apb(1'b0, `CXS_OFF_OPTION, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `CXS_OFF_STATUS, 32'h0);
    chk({rd[4:3], rd[0]}, 3'b010);
  endtask
  // Mid-run power-on reset; the option write must land inside the short start-up hold
  task t_pu_sleep();
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, `CXS_OFF_OPTION, 32'h2);
    repeat (4) @(posedge pclk);
    chk({asleep, listen}, 2'b11);
    i_node.sof();
    repeat (2) @(posedge pclk);
    hold_end();
    chk({listen, ack_en}, 2'b10);
    i_node.frame(1'b1);
    repeat (2) @(posedge pclk);
    chk(ack_en, 1'b1);
    i_node.frame(1'b0);
    repeat (2) @(posedge pclk);
    chk(listen, 1'b1);
    i_node.frame(1'b1);
    repeat (2) @(posedge pclk);
    chk({listen, amsg}, 2'b01);
  endtask
  task final_report();
    $display("mismatches %0d comparisons %0d", n_fail, samples_checked);
    if (n_fail == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    ext_rst_n = 1'b1;
    gpio_in = 8'h00;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    hold_end();
    t_regs();
    t_idle();
    t_can_wake();
    t_gpio_wake();
    t_pin_reset();
    t_pu_sleep();
    final_report();
  end
  // Whole run is a few hundred cycles; this is a hang guard only
  initial begin
    #400000;
    n_fail++;
    final_report();
  end
endmodule // testbench
